// File: hw/psp_regs.svh
// Purpose: register map, field positions and reset values of the parallel slave port
// Assumes: 32-bit AHB-Lite register window, one register per aligned word
// Notes:   definitions only
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// ==========================================================================
// register byte offsets
`define PSP_OFS_DATA       8'h00
`define PSP_OFS_CTRL       8'h04
`define PSP_OFS_DATA_DIR   8'h08
`define PSP_OFS_CTRL_DIR   8'h0C
`define PSP_OFS_IRQ_STAT   8'h10
`define PSP_OFS_IRQ_MASK   8'h14
`define PSP_OFS_PIN_IN     8'h18

// ==========================================================================
// parallel_port_control fields
`define PSP_CTRL_IBF_BIT   7
`define PSP_CTRL_OBF_BIT   6
`define PSP_CTRL_INPUT_OVERRUN_BIT  5
`define PSP_CTRL_MODE_BIT  4

// ==========================================================================
// interrupt status and mask fields
`define PSP_IRQ_PORT_BIT   0
`define PSP_IRQ_OVR_BIT    1
`define PSP_IRQ_W          2

// ==========================================================================
// reset values, slave-mode control direction and synchroniser depth
`define PSP_RST_CTRL       8'h00
`define PSP_RST_DATA       8'h00
`define PSP_RST_DATA_DIR   8'hFF
`define PSP_RST_CTRL_DIR   3'h7
`define PSP_RST_IRQ        2'h0
`define PSP_SLAVE_DIR      3'h7
`define PSP_SYNC_STAGES    2

`endif

// File: hw/psp_pkg.sv
// Purpose: shared types of the parallel slave port
// Assumes: nothing
// Notes:   constants live in psp_regs.svh
package psp_pkg;

   // ==========================================================================
   // external access state, one-hot
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } port_state_t;

endpackage

// File: hw/psp_sync.sv
// Purpose: multi-flop synchroniser for asynchronous pin inputs
// Assumes: inputs idle at the reset value given
// Notes:   the first stage feeds only the next stage
`timescale 1ns/100ps
module psp_sync #(
   parameter int              WIDTH  = 11,
   parameter int              STAGES = 2,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] stage_q [STAGES];

   // ==========================================================================
   // elaboration check
   if (STAGES < 2) begin : g_chk
      $error("psp_sync needs at least two stages");
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_q[i] <= RST_VAL;
         end
      end else begin
         stage_q[0] <= d_i;
         for (int i = 1; i < STAGES; i++) begin
            stage_q[i] <= stage_q[i-1];
         end
      end
   end

   assign q_o = stage_q[STAGES-1];

endmodule

// File: hw/parallel_slave_port.sv
// Purpose: 8-bit parallel slave port with AHB-Lite register access
// Assumes: MCLK_I at 10 MHz, synchronous active-low reset, one AHB-Lite master
// Notes:   strobes and data pins are asynchronous and pass two flops first
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "psp_regs.svh"

// Summary of operation
// [RULE1] mode bit set makes data pins a slave port, clear gives plain I/O
// [RULE2] external master reads or writes the latch anytime, clock unrelated
// [RULE3] in slave mode three pins act as active-low read, write, select
// [RULE4] control pins serve only when their direction bits are all input
// [RULE5] write runs while select and write low, ends when either goes high
// [RULE6] end of external write sets port interrupt flag and input-full
// [RULE7] select and read low starts a read; latch is driven onto pins
// [RULE8] CPU write during an external read shows at once, output-full stays clear
// [RULE9] select or read high releases pins and sets port interrupt flag
// [RULE10] input-full reads one while a received word waits for the CPU
// [RULE11] output-full reads one until the external master reads the word
// [RULE12] overrun set by write onto unread word; only software zero clears it
// [RULE13] mode bit read/write; low four control bits read zero
// [RULE14] whole control register resets to zero, port starts as plain I/O
// [RULE15] CPU data read clears input-full; CPU write outside read sets output-full
// [RULE16] select and strobes are synchronised before access edges are found
module parallel_slave_port
   import psp_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              MCLK_I,
   input  wire logic              RST_N_I,
   input  wire logic              HSEL_I,
   input  wire logic [ADDR_W-1:0] HADDR_I,
   input  wire logic [1:0]        HTRANS_I,
   input  wire logic              HWRITE_I,
   input  wire logic [2:0]        HSIZE_I,
   input  wire logic [31:0]       HWDATA_I,
   input  wire logic              HREADY_I,
   output logic      [31:0]       HRDATA_O,
   output logic                   HREADYOUT_O,
   output logic                   HRESP_O,
   input  wire logic [7:0]        PD_I,
   output logic      [7:0]        PD_O,
   output logic      [7:0]        PD_OE_N_O,
   input  wire logic              RD_N_I,
   input  wire logic              WR_N_I,
   input  wire logic              CS_N_I,
   output logic                   IRQ_O
);

   // ==========================================================================
   // elaboration check
   if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
      $error("parallel_slave_port needs ADDR_W between 5 and 8");
   end

   // ==========================================================================
   // pin synchronisers
   logic [10:0] pins_s;
   logic [7:0]  din_s;
   logic        rd_n_s;
   logic        wr_n_s;
   logic        cs_n_s;

   // the external side runs unrelated to MCLK_I, so nothing is read raw  RULE2
   psp_sync #(
      .WIDTH   (11),
      .STAGES  (`PSP_SYNC_STAGES),
      .RST_VAL (11'h7FF)
   ) u_sync (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .d_i     ({CS_N_I, WR_N_I, RD_N_I, PD_I}),
      .q_o     (pins_s)
   ); // RULE16

   assign din_s  = pins_s[7:0];
   assign rd_n_s = pins_s[8];
   assign wr_n_s = pins_s[9];
   assign cs_n_s = pins_s[10];

   // ==========================================================================
   // registers
   logic              mode_q;
   logic              ibf_q;
   logic              ibf_d;
   logic              obf_q;
   logic              input_overrun_q;
   logic [7:0]        latch_q;
   logic [7:0]        latch_d;
   logic [7:0]        cap_q;
   logic [7:0]        data_dir_q;
   logic [2:0]        ctrl_dir_q;
   logic [1:0]        irq_stat_q;
   logic [1:0]        irq_stat_d;
   logic [1:0]        irq_mask_q;
   port_state_t       state_q;
   port_state_t       state_d;

   // ==========================================================================
   // AHB-Lite slave, zero wait states
   logic              acc;
   logic              wr_phase_q;
   logic [ADDR_W-1:0] addr_q;
   logic              ctrl_rd_q;
   logic              cpu_rd;
   logic              cpu_data_wr;
   logic              cpu_ctrl_wr;
   logic [31:0]       rdata;

   assign acc    = HSEL_I && HTRANS_I[1] && HREADY_I;
   assign cpu_rd = acc && !HWRITE_I && (HADDR_I == ADDR_W'(`PSP_OFS_DATA));

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         wr_phase_q <= 1'b0;
         addr_q     <= '0;
         ctrl_rd_q  <= 1'b0;
      end else begin
         wr_phase_q <= acc && HWRITE_I;
         addr_q     <= HADDR_I;
         ctrl_rd_q  <= acc && !HWRITE_I && (HADDR_I == ADDR_W'(`PSP_OFS_CTRL));
      end
   end

   assign cpu_data_wr = wr_phase_q && (addr_q == ADDR_W'(`PSP_OFS_DATA));
   assign cpu_ctrl_wr = wr_phase_q && (addr_q == ADDR_W'(`PSP_OFS_CTRL));

   always_comb begin
      rdata = 32'h0000_0000;
      unique case (HADDR_I)
         ADDR_W'(`PSP_OFS_DATA):     rdata[7:0] = latch_q;
         // low nibble stays zero  RULE13
         ADDR_W'(`PSP_OFS_CTRL):     rdata[7:0] = {ibf_q, obf_q, input_overrun_q, mode_q, 4'h0};
         ADDR_W'(`PSP_OFS_DATA_DIR): rdata[7:0] = data_dir_q;
         ADDR_W'(`PSP_OFS_CTRL_DIR): rdata[2:0] = ctrl_dir_q;
         ADDR_W'(`PSP_OFS_IRQ_STAT): rdata[1:0] = irq_stat_q;
         ADDR_W'(`PSP_OFS_IRQ_MASK): rdata[1:0] = irq_mask_q;
         ADDR_W'(`PSP_OFS_PIN_IN):   rdata[7:0] = din_s;
         default:                    rdata      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         HRDATA_O    <= 32'h0000_0000;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end else begin
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
         if (acc && !HWRITE_I) begin
            HRDATA_O <= rdata;
         end
      end
   end

   // ==========================================================================
   // configuration registers
   localparam logic [7:0] CTRL_RST = `PSP_RST_CTRL;

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         mode_q     <= CTRL_RST[`PSP_CTRL_MODE_BIT]; // RULE14
         data_dir_q <= `PSP_RST_DATA_DIR;
         ctrl_dir_q <= `PSP_RST_CTRL_DIR;
         irq_mask_q <= `PSP_RST_IRQ;
      end else begin
         if (cpu_ctrl_wr) begin
            mode_q <= HWDATA_I[`PSP_CTRL_MODE_BIT]; // RULE13
         end
         if (wr_phase_q && addr_q == ADDR_W'(`PSP_OFS_DATA_DIR)) begin
            data_dir_q <= HWDATA_I[7:0];
         end
         if (wr_phase_q && addr_q == ADDR_W'(`PSP_OFS_CTRL_DIR)) begin
            ctrl_dir_q <= HWDATA_I[2:0];
         end
         if (wr_phase_q && addr_q == ADDR_W'(`PSP_OFS_IRQ_MASK)) begin
            irq_mask_q <= HWDATA_I[1:0];
         end
      end
   end

   // ==========================================================================
   // external access detection
   logic slave_en;
   logic wr_act;
   logic rd_act;
   logic wr_end;
   logic rd_start;
   logic rd_end;

   // strobes only count with all three control pins set as inputs  RULE4
   assign slave_en = mode_q && (ctrl_dir_q == `PSP_SLAVE_DIR); // RULE1
   assign wr_act   = slave_en && !cs_n_s && !wr_n_s; // RULE3
   assign rd_act   = slave_en && !cs_n_s && !rd_n_s; // RULE3

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (wr_act) begin
               state_d = ST_WRITE;
            end else if (rd_act) begin
               state_d = ST_READ;
            end
         end
         ST_WRITE: begin
            if (!wr_act) begin
               state_d = ST_IDLE; // RULE5
            end
         end
         ST_READ: begin
            if (!rd_act) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign wr_end   = (state_q == ST_WRITE) && !wr_act;
   assign rd_start = (state_q == ST_IDLE) && !wr_act && rd_act;
   assign rd_end   = (state_q == ST_READ) && !rd_act;

   // the word still on the pins in the last active cycle is the one kept  RULE5
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         cap_q <= `PSP_RST_DATA;
      end else if (wr_act) begin
         cap_q <= din_s;
      end
   end

   // ==========================================================================
   // data latch and status flags
   always_comb begin
      latch_d = latch_q;
      if (cpu_data_wr) begin
         latch_d = HWDATA_I[7:0]; // RULE8
      end
      if (wr_end) begin
         latch_d = cap_q;
      end
   end

   // hardware set wins over the CPU read that clears  RULE15
   always_comb begin
      ibf_d = ibf_q;
      if (cpu_rd) begin
         ibf_d = 1'b0;
      end
      if (wr_end) begin
         ibf_d = 1'b1; // RULE6 RULE10
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         latch_q <= `PSP_RST_DATA;
         ibf_q   <= 1'b0;
      end else begin
         latch_q <= latch_d;
         ibf_q   <= ibf_d;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         obf_q <= 1'b0;
      end else if (cpu_data_wr && state_q != ST_READ) begin
         obf_q <= 1'b1; // RULE15
      end else if (rd_start) begin
         obf_q <= 1'b0; // RULE11
      end
   end

   // writes of one to the overrun bit are ignored  RULE12
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         input_overrun_q <= 1'b0;
      end else if (wr_end && ibf_q && !cpu_rd) begin
         input_overrun_q <= 1'b1; // RULE12
      end else if (cpu_ctrl_wr && !HWDATA_I[`PSP_CTRL_INPUT_OVERRUN_BIT]) begin
         input_overrun_q <= 1'b0;
      end
   end

   // ==========================================================================
   // interrupt status, write one to clear, set wins
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (wr_phase_q && addr_q == ADDR_W'(`PSP_OFS_IRQ_STAT)) begin
         irq_stat_d = irq_stat_q & ~HWDATA_I[1:0];
      end
      if (wr_end || rd_end) begin
         irq_stat_d[`PSP_IRQ_PORT_BIT] = 1'b1; // RULE6 RULE9
      end
      if (wr_end && ibf_q && !cpu_rd) begin
         irq_stat_d[`PSP_IRQ_OVR_BIT] = 1'b1;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         irq_stat_q <= `PSP_RST_IRQ;
         IRQ_O      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         IRQ_O      <= |(irq_stat_d & irq_mask_q);
      end
   end

   // ==========================================================================
   // pin drivers, registered one cycle behind the decision
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         PD_O      <= `PSP_RST_DATA;
         PD_OE_N_O <= 8'hFF;
      end else begin
         PD_O <= latch_d; // RULE8
         if (!mode_q) begin
            PD_OE_N_O <= data_dir_q; // RULE1
         end else if (rd_act && !wr_act && state_q != ST_WRITE) begin
            PD_OE_N_O <= 8'h00; // RULE7
         end else begin
            PD_OE_N_O <= 8'hFF; // RULE9
         end
      end
   end

   // ==========================================================================
   // checks
   property p_gpio_idle;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      !slave_en |=> state_q == ST_IDLE;
   endproperty
   a_gpio_idle: assert property (p_gpio_idle) else $error("port active without slave enable"); // RULE1 RULE4

   property p_write_end;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      wr_end |=> ibf_q && irq_stat_q[`PSP_IRQ_PORT_BIT] && latch_q == $past(cap_q);
   endproperty
   a_write_end: assert property (p_write_end) else $error("write end did not set flags"); // RULE6

   property p_read_drive;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      (state_q == ST_READ && rd_act) |=> PD_OE_N_O == 8'h00 && PD_O == latch_q;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read not driving pins"); // RULE7

   property p_read_end;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      rd_end |=> PD_OE_N_O == 8'hFF && irq_stat_q[`PSP_IRQ_PORT_BIT];
   endproperty
   a_read_end: assert property (p_read_end) else $error("read end did not release"); // RULE9

   property p_write_in_read;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      (state_q == ST_READ && rd_act && cpu_data_wr) |=> !obf_q && PD_O == $past(HWDATA_I[7:0]);
   endproperty
   a_write_in_read: assert property (p_write_in_read) else $error("read-time write wrong"); // RULE8

   property p_overrun_hold;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      input_overrun_q && !(cpu_ctrl_wr && !HWDATA_I[`PSP_CTRL_INPUT_OVERRUN_BIT]) |=> input_overrun_q;
   endproperty
   a_overrun_hold: assert property (p_overrun_hold) else $error("overrun lost"); // RULE12

   property p_ctrl_low_zero;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      ctrl_rd_q |-> HRDATA_O[3:0] == 4'h0 && HRDATA_O[31:8] == 24'h000000;
   endproperty
   a_ctrl_low_zero: assert property (p_ctrl_low_zero) else $error("control spare bits set"); // RULE13

   property p_reset_ctrl;
      @(posedge MCLK_I)
      !RST_N_I |=> !mode_q && !ibf_q && !obf_q && !input_overrun_q;
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not zero after reset"); // RULE14

   property p_cpu_read_clear;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      (cpu_rd && !wr_end) |=> !ibf_q;
   endproperty
   a_cpu_read_clear: assert property (p_cpu_read_clear) else $error("data read kept full"); // RULE15

   property p_sync_select;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      $rose(CS_N_I) && state_q != ST_IDLE |=> state_q != ST_IDLE;
   endproperty
   a_sync_select: assert property (p_sync_select) else $error("select acted unsynchronised"); // RULE16

endmodule

// File: bench/ext_cpu_model.sv
// Purpose: behavioural 8-bit bus master on the far side of the slave port
// Assumes: strobes and data change by non-blocking assignment after a rising edge
// Notes:   a released data line shows the inverse of the last byte driven
`timescale 1ns/100ps
module ext_cpu_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] pd_i,
   output logic      [7:0] pd_o,
   output logic            sel_n_o,
   output logic            rstrobe_n_o,
   output logic            wstrobe_n_o
);
   // ==========================================================================
   // idle levels
   initial begin
      pd_o        = 8'hFF;
      sel_n_o     = 1'b1;
      rstrobe_n_o = 1'b1;
      wstrobe_n_o = 1'b1;
   end

   // ==========================================================================
   // accesses
   // strobes stay six clocks each side; the port needs three to see them
   task automatic wr_byte(input logic [7:0] d);
      @(posedge clk_i);
      sel_n_o     <= 1'b0;
      wstrobe_n_o <= 1'b0;
      pd_o        <= d;
      repeat (6) @(posedge clk_i);
      sel_n_o     <= 1'b1;
      wstrobe_n_o <= 1'b1;
      @(posedge clk_i);
      pd_o        <= ~d;
      repeat (6) @(posedge clk_i);
   endtask

   task automatic rd_start();
      @(posedge clk_i);
      sel_n_o     <= 1'b0;
      rstrobe_n_o <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask

   task automatic rd_end(output logic [7:0] d);
      @(posedge clk_i);
      d = pd_i;
      sel_n_o     <= 1'b1;
      rstrobe_n_o <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// File: bench/tb_top.sv
// Purpose: self-checking bench of the parallel slave port
// Assumes: zero-wait AHB-Lite slave, one word per register
// Notes:   pin level is resolved here from the device enables and the model drive
`timescale 1ns/100ps
`include "psp_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module tb_top;
   logic        mclk;
   logic        rst_n;
   logic        hsel;
   logic [2:0]  hsize;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic [7:0]  pd_out;
   logic [7:0]  pd_oe_n;
   logic [7:0]  pd_ext;
   logic [7:0]  pd_bus;
   logic        sel_n;
   logic        rstb_n;
   logic        wstb_n;
   logic        irq;
   logic [7:0]  b;
   int          mismatches;
   int          n_tests;
   int          cycles;

   assign pd_bus = (pd_oe_n & pd_ext) | (~pd_oe_n & pd_out);

   parallel_slave_port DUT (.MCLK_I(mclk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .PD_I(pd_bus), .PD_O(pd_out), .PD_OE_N_O(pd_oe_n), .RD_N_I(rstb_n), .WR_N_I(wstb_n),
      .CS_N_I(sel_n), .IRQ_O(irq));

   ext_cpu_model ext (.clk_i(mclk), .pd_i(pd_bus), .pd_o(pd_ext), .sel_n_o(sel_n),
      .rstrobe_n_o(rstb_n), .wstrobe_n_o(wstb_n));

   // ==========================================================================
   // clock, timeout, verdict
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // the whole run takes well under two thousand clocks
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         end_sim();
      end
   end

   // ==========================================================================
   // bus tasks
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
      `CHK(hresp, 1'b0)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, a, 32'h0, x);
      `CHK(x, e)
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_reset();
      rst_n <= 1'b0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      `CHK(pd_oe_n, 8'hFF)
      `CHK(irq, 1'b0)
      rchk(`PSP_OFS_CTRL, 32'h0);
      rchk(`PSP_OFS_DATA_DIR, 32'hFF);
      rchk(`PSP_OFS_CTRL_DIR, 32'h7);
      rchk(`PSP_OFS_IRQ_STAT, 32'h0);
      rchk(`PSP_OFS_IRQ_MASK, 32'h0);
      // a transfer without slave select must leave the registers alone
      hsel <= 1'b0;
      wr(`PSP_OFS_IRQ_MASK, 32'h3);
      hsel <= 1'b1;
      rchk(`PSP_OFS_IRQ_MASK, 32'h0);
      wr(8'h1C, 32'hFFFFFFFF);
      rchk(8'h1C, 32'h0);
      rchk(`PSP_OFS_CTRL, 32'h0);
   endtask

   task automatic t_gpio();
      wr(`PSP_OFS_DATA_DIR, 32'h0F);
      wr(`PSP_OFS_DATA, 32'h3C);
      repeat (2) @(posedge mclk);
      `CHK(pd_oe_n, 8'h0F)
      `CHK(pd_out, 8'h3C)
      ext.wr_byte(8'hA5);
      // upper nibble driven by the port, lower nibble shows the released model byte
      rchk(`PSP_OFS_PIN_IN, 32'h3A);
      rchk(`PSP_OFS_IRQ_STAT, 32'h0);
      rchk(`PSP_OFS_DATA, 32'h3C);
      wr(`PSP_OFS_DATA_DIR, 32'hFF);
   endtask

   task automatic t_dir();
      wr(`PSP_OFS_CTRL_DIR, 32'h3);
      wr(`PSP_OFS_CTRL, 32'h10);
      ext.wr_byte(8'h77);
      rchk(`PSP_OFS_IRQ_STAT, 32'h0);
      rchk(`PSP_OFS_DATA, 32'h3C);
      wr(`PSP_OFS_CTRL_DIR, 32'h7);
   endtask

   task automatic t_read();
      wr(`PSP_OFS_DATA, 32'hC3);
      rchk(`PSP_OFS_CTRL, 32'h50);
      ext.rd_start();
      `CHK(pd_oe_n, 8'h00)
      `CHK(pd_out, 8'hC3)
      ext.rd_end(b);
      `CHK(b, 8'hC3)
      `CHK(pd_oe_n, 8'hFF)
      `CHK(irq, 1'b0)
      rchk(`PSP_OFS_CTRL, 32'h10);
      rchk(`PSP_OFS_IRQ_STAT, 32'h1);
      wr(`PSP_OFS_IRQ_STAT, 32'h1);
      rchk(`PSP_OFS_IRQ_STAT, 32'h0);
   endtask

   task automatic t_live();
      ext.rd_start();
      wr(`PSP_OFS_DATA, 32'h96);
      repeat (2) @(posedge mclk);
      `CHK(pd_out, 8'h96)
      ext.rd_end(b);
      `CHK(b, 8'h96)
      rchk(`PSP_OFS_CTRL, 32'h10);
      wr(`PSP_OFS_IRQ_STAT, 32'h1);
   endtask

   task automatic t_write();
      wr(`PSP_OFS_IRQ_MASK, 32'h1);
      rchk(`PSP_OFS_IRQ_MASK, 32'h1);
      ext.wr_byte(8'h5A);
      `CHK(irq, 1'b1)
      rchk(`PSP_OFS_CTRL, 32'h90);
      rchk(`PSP_OFS_DATA, 32'h5A);
      rchk(`PSP_OFS_CTRL, 32'h10);
      wr(`PSP_OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge mclk);
      `CHK(irq, 1'b0)
   endtask

   task automatic t_overrun();
      ext.wr_byte(8'h11);
      ext.wr_byte(8'h22);
      rchk(`PSP_OFS_CTRL, 32'hB0);
      rchk(`PSP_OFS_IRQ_STAT, 32'h3);
      wr(`PSP_OFS_CTRL, 32'hFF);
      rchk(`PSP_OFS_CTRL, 32'hB0);
      rchk(`PSP_OFS_DATA, 32'h22);
      wr(`PSP_OFS_CTRL, 32'h10);
      rchk(`PSP_OFS_CTRL, 32'h10);
      wr(`PSP_OFS_IRQ_STAT, 32'h3);
      rchk(`PSP_OFS_IRQ_STAT, 32'h0);
   endtask

   // ==========================================================================
   // main sequence
   initial begin
      rst_n      = 1'b0;
      hsel       = 1'b1;
      hsize      = 3'h2;
      haddr      = 8'h00;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hwdata     = 32'h0;
      mismatches = 0;
      n_tests    = 0;
      cycles     = 0;
      t_reset();
      t_gpio();
      t_dir();
      t_read();
      t_live();
      t_write();
      t_overrun();
      t_reset();
      end_sim();
   end
endmodule
